/* rtl/dcc_clkgen.sv */
// Clock divider producing a one-cycle enable and a square wave
`timescale 1ns/1ps
module dcc_clkgen (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Control
	input wire logic run,
	input wire logic [15:0] half_period,
	// Outputs
	output logic tick,
	output logic clk_out
);
	logic [15:0] cnt_q;

	// Toggle output every half period
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cnt_q <= 16'h0000;
			clk_out <= 1'b0;
			tick <= 1'b0;
		end else if (!run) begin
			cnt_q <= 16'h0000;
			clk_out <= 1'b0;
			tick <= 1'b0;
		end else if (cnt_q >= half_period) begin
			cnt_q <= 16'h0000;
			clk_out <= ~clk_out;
			tick <= ~clk_out;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule : dcc_clkgen

/* rtl/dcc_consts.svh */
// Constants for the loop control and clock output block
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH
// Register offsets
`define DCC_REG_MODE 4'h0
`define DCC_REG_CTRL 4'h1
`define DCC_REG_SB_DIV 4'h2
`define DCC_REG_SB_RATIO 4'h3
`define DCC_REG_DIFF_SEL 4'h4
`define DCC_REG_STATUS 4'h5
// Control register fields
`define DCC_CTRL_HS_SW_BIT 0
`define DCC_CTRL_HS_SRC_BIT 1
`define DCC_CTRL_MODE_SRC_BIT 2
`define DCC_CTRL_B_DIV_BIT 3
// Synthesizer rates in kHz, ratio and diff select reset values
`define DCC_KHZ_STEP 8
`define DCC_KHZ_LOW 2
`define DCC_KHZ_MAX 77760
`define DCC_SB_A_KHZ_RST 16'h0608
`define DCC_SB_RATIO_RST 8'h02
`define DCC_DIFF_SEL_RST 3'h4
// Reset timing
`define DCC_RST_MIN_NS 300
`define DCC_CLK_NS 10
`define DCC_BOOT_CYC 2'h2
`define DCC_RST_MIN_CYC ((`DCC_RST_MIN_NS + `DCC_CLK_NS - 1) / `DCC_CLK_NS)
`endif

/* rtl/dcc_pkg.sv */
// Types for the loop control and clock output block
package dcc_pkg;
	typedef enum logic [1:0] {
		DCC_MODE_AUTO,
		DCC_MODE_NORMAL,
		DCC_MODE_HOLDOVER,
		DCC_MODE_FREERUN
	} dcc_mode_t;

	// Synchronised control pins
	typedef struct packed {
		logic [1:0] mode_pins;
		logic hitless;
		logic diff_a_en;
		logic diff_b_en;
	} dcc_ctl_t;

	// Register bus request
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} dcc_bus_t;
endpackage : dcc_pkg

/* rtl/dcc_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dcc_sync #(
	parameter int W = 5
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Data
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// Two stages, first stage read only by the second
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : dcc_sync

/* rtl/dcc_top.sv */
// Loop control pins, mode selection and clock outputs
`timescale 1ns/1ps
`include "dcc_consts.svh"
// Overview of operation
// - Hitless enable high keeps hitless switching
// - Hitless enable low realigns phase to reference
// - Register may override hitless pin
// - Mode pins latched at reset give default
// - Mode from pins or mode register
// - Output A driven when enabled, else off
// - Output B driven when enabled, else off
// - Feedback copy follows primary feedback input
// - Secondary reference copied straight, not hitless
// - Synth clock A rate, default 1.544 MHz
// - Synth clock B ratio of A, default 3.088
// - Output A frequency select, default 4, a 10-cycle period (10 MHz)
module dcc_top (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Control pins
	input wire logic primary_mode_pin_lo,
	input wire logic primary_mode_pin_hi,
	input wire logic primary_hitless_enable,
	input wire logic diffout_a_enable,
	input wire logic diffout_b_enable,
	// Reference clocks from the loops
	input wire logic primary_feedback_in,
	input wire logic secondary_selector_in,
	input wire logic ref_switch_event,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Loop control outputs
	output dcc_pkg::dcc_mode_t primary_mode,
	output logic hitless_active,
	output logic phase_realign,
	// Clock outputs
	output logic synth_b_clock_a,
	output logic synth_b_clock_b,
	output logic loop_feedback_copy,
	output logic secondary_selected_ref_copy,
	output logic diffout_a_pos,
	output logic diffout_a_neg,
	output logic diffout_a_oe,
	output logic diffout_b_pos,
	output logic diffout_b_neg,
	output logic diffout_b_oe
);
	dcc_pkg::dcc_ctl_t pins_raw;
	dcc_pkg::dcc_ctl_t pins;
	logic [1:0] ref_raw;
	logic [1:0] ref_s;
	logic init_q;
	logic [1:0] boot_q;
	logic [1:0] mode_reg_q;
	logic [3:0] ctrl_q;
	logic [15:0] sb_a_khz_q;
	logic [7:0] sb_ratio_q;
	logic [2:0] diff_sel_q;
	logic hs_eff;
	logic hs_prev_q;
	logic sw_prev_q;
	logic [1:0] mode_now;
	logic [15:0] half_a;
	logic [15:0] half_b;
	logic [15:0] half_d;
	logic a_prev_q;
	logic a_edge;
	logic clk_a;
	logic clk_b;
	logic clk_d;
	logic [7:0] div_cnt_q;
	logic div_clk_q;

	// Half period in system cycles for a rate in kHz
	// Zero rate is treated as one to keep the divider defined
	function automatic logic [15:0] half_cycles(input logic [15:0] khz);
		logic [31:0] h;
		h = 32'd50000 / {16'h0000, (khz == 16'h0000) ? 16'h0001 : khz};
		half_cycles = (h == 32'h0) ? 16'h0000 : h[15:0] - 16'h0001;
	endfunction : half_cycles

	// Legal synth rate: multiple of 8 kHz up to max cut to 16 bits (12224), or 2 kHz
	function automatic logic rate_ok(input logic [15:0] khz);
		rate_ok = (khz == 16'(`DCC_KHZ_LOW)) ||
			(khz != 16'h0000 && khz <= 16'(`DCC_KHZ_MAX) && (khz % 16'(`DCC_KHZ_STEP)) == 16'h0000);
	endfunction : rate_ok

	assign pins_raw = '{mode_pins: {primary_mode_pin_hi, primary_mode_pin_lo},
		hitless: primary_hitless_enable, diff_a_en: diffout_a_enable, diff_b_en: diffout_b_enable};
	assign ref_raw = {secondary_selector_in, primary_feedback_in};

	// Pin synchronisers
	// Mode pins must stay steady across reset release
	dcc_sync #(.W(5)) u_pin_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.async_in(pins_raw),
		.sync_out(pins)
	);

	dcc_sync #(.W(2)) u_ref_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.async_in(ref_raw),
		.sync_out(ref_s)
	);

	// Count two edges so the synchronised pins are valid
	// before the default mode is taken from them
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			boot_q <= 2'h0;
		end else if (boot_q != `DCC_BOOT_CYC) begin
			boot_q <= boot_q + 2'h1;
		end
	end

	// Capture default mode from pins after reset release
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			init_q <= 1'b0;
			mode_reg_q <= 2'h0;
		end else if (!init_q) begin
			if (boot_q == `DCC_BOOT_CYC) begin
				init_q <= 1'b1;
				mode_reg_q <= pins.mode_pins;
			end
		end else if (reg_wr && reg_addr == `DCC_REG_MODE) begin
			mode_reg_q <= reg_wdata[1:0];
		end
	end

	// Control and configuration registers
	// Refused writes leave the old value in place
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ctrl_q <= 4'h0;
			sb_a_khz_q <= `DCC_SB_A_KHZ_RST;
			sb_ratio_q <= `DCC_SB_RATIO_RST;
			diff_sel_q <= `DCC_DIFF_SEL_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				`DCC_REG_CTRL: ctrl_q <= reg_wdata[3:0];
				`DCC_REG_SB_DIV: begin
					if (rate_ok(reg_wdata)) begin
						sb_a_khz_q <= reg_wdata;
					end
				end
				`DCC_REG_SB_RATIO: begin
					if (reg_wdata[7:0] != 8'h00) begin
						sb_ratio_q <= reg_wdata[7:0];
					end
				end
				`DCC_REG_DIFF_SEL: diff_sel_q <= reg_wdata[2:0];
				default: ;
			endcase
		end
	end

	// Mode source: live pins or register
	assign mode_now = ctrl_q[`DCC_CTRL_MODE_SRC_BIT] ? mode_reg_q : pins.mode_pins;

	// Hitless source: pin or software bit
	// Previous levels reset low, the idle levels, so no false realign
	assign hs_eff = ctrl_q[`DCC_CTRL_HS_SRC_BIT] ? ctrl_q[`DCC_CTRL_HS_SW_BIT] : pins.hitless;

	// Loop control outputs
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			primary_mode <= dcc_pkg::DCC_MODE_AUTO;
			hitless_active <= 1'b0;
			phase_realign <= 1'b0;
			hs_prev_q <= 1'b0;
			sw_prev_q <= 1'b0;
		end else begin
			primary_mode <= init_q ? dcc_pkg::dcc_mode_t'(mode_now) : dcc_pkg::dcc_mode_t'(pins.mode_pins);
			hitless_active <= hs_eff;
			hs_prev_q <= hs_eff;
			sw_prev_q <= ref_switch_event;
			// Realign on switch when hitless off, or on falling enable
			phase_realign <= (!hs_eff && (ref_switch_event && !sw_prev_q)) ||
				(hs_prev_q && !hs_eff);
		end
	end

	// Buffered copies of loop references
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			loop_feedback_copy <= 1'b0;
			secondary_selected_ref_copy <= 1'b0;
		end else begin
			loop_feedback_copy <= ref_s[0];
			secondary_selected_ref_copy <= ref_s[1];
		end
	end

	// Synthesizer clock A generator
	assign half_a = half_cycles(sb_a_khz_q);
	assign half_b = half_cycles(16'(sb_a_khz_q * sb_ratio_q));
	assign half_d = 16'(diff_sel_q);

	dcc_clkgen u_synth_a (
		.clk_sys(clk_sys),
		.reset(reset),
		.run(init_q),
		.half_period(half_a),
		.tick(),
		.clk_out(clk_a)
	);

	// Multiplied B from its own generator
	dcc_clkgen u_synth_b (
		.clk_sys(clk_sys),
		.reset(reset),
		.run(init_q),
		.half_period(half_b),
		.tick(),
		.clk_out(clk_b)
	);

	// Either edge of clock A steps the divider
	assign a_edge = clk_a ^ a_prev_q;

	// Divided B: toggles every ratio edges of A, so period is ratio times A
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			div_cnt_q <= 8'h00;
			div_clk_q <= 1'b0;
			a_prev_q <= 1'b0;
		end else begin
			a_prev_q <= clk_a;
			if (a_edge) begin
				if (div_cnt_q + 8'h01 >= sb_ratio_q) begin
					div_cnt_q <= 8'h00;
					div_clk_q <= ~div_clk_q;
				end else begin
					div_cnt_q <= div_cnt_q + 8'h01;
				end
			end
		end
	end

	// Differential rate generator
	dcc_clkgen u_diff (
		.clk_sys(clk_sys),
		.reset(reset),
		.run(init_q),
		.half_period(half_d),
		.tick(),
		.clk_out(clk_d)
	);

	// Output clock registers and driver enables
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			synth_b_clock_a <= 1'b0;
			synth_b_clock_b <= 1'b0;
			diffout_a_pos <= 1'b0;
			diffout_a_neg <= 1'b0;
			diffout_a_oe <= 1'b0;
			diffout_b_pos <= 1'b0;
			diffout_b_neg <= 1'b0;
			diffout_b_oe <= 1'b0;
		end else begin
			synth_b_clock_a <= clk_a;
			// Bit set selects the divided path; clear gives the
			// multiplied clock, which is the reset default
			synth_b_clock_b <= ctrl_q[`DCC_CTRL_B_DIV_BIT] ? div_clk_q : clk_b;
			diffout_a_oe <= pins.diff_a_en;
			diffout_a_pos <= clk_d;
			diffout_a_neg <= ~clk_d;
			diffout_b_oe <= pins.diff_b_en;
			diffout_b_pos <= clk_d;
			diffout_b_neg <= ~clk_d;
		end
	end

	// Read data, one cycle after the strobe
	// Status shows the synchronised pins, not the raw ones
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`DCC_REG_MODE: reg_rdata <= {14'h0000, mode_reg_q};
				`DCC_REG_CTRL: reg_rdata <= {12'h000, ctrl_q};
				`DCC_REG_SB_DIV: reg_rdata <= sb_a_khz_q;
				`DCC_REG_SB_RATIO: reg_rdata <= {8'h00, sb_ratio_q};
				`DCC_REG_DIFF_SEL: reg_rdata <= {13'h0000, diff_sel_q};
				`DCC_REG_STATUS: reg_rdata <= {11'h000, pins.diff_b_en, pins.diff_a_en, hs_eff, primary_mode};
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end
endmodule : dcc_top

/* verification/dcc_board.sv */
// Board control model: reset, pins and loop clocks
`timescale 1ns/1ps
module dcc_board (
	// Clock
	input wire logic clk_sys,
	// Board drive
	output logic reset,
	output dcc_pkg::dcc_ctl_t pins,
	output logic feedback_wave,
	output logic selector_wave
);
	logic [7:0] tick_q = 8'h0;
	// Pull-ups idle high, reset held from power-up
	initial begin
		reset = 1'b1;
		pins = '1;
	end
	// Slow loop clocks
	always @(posedge clk_sys) tick_q <= tick_q + 8'h1;
	assign feedback_wave = tick_q[3];
	assign selector_wave = tick_q[4];
	// Reset with mode pins steady across it
	task automatic power_up(input logic [1:0] mode);
		@(posedge clk_sys);
		pins.mode_pins <= mode;
		reset <= 1'b1;
		repeat (31) @(posedge clk_sys);
		reset <= 1'b0;
	endtask : power_up
	// Drive all pins at once
	task automatic drive(input dcc_pkg::dcc_ctl_t ctl);
		@(posedge clk_sys);
		pins <= ctl;
	endtask : drive
endmodule : dcc_board

/* verification/dcc_top_properties.sv */
// Assertions on the control pins and register port
`timescale 1ns/1ps
module dcc_checker (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Pins
	input wire logic primary_mode_pin_lo,
	input wire logic primary_mode_pin_hi,
	input wire logic primary_hitless_enable,
	input wire logic diffout_a_enable,
	input wire logic diffout_b_enable,
	input wire logic primary_feedback_in,
	input wire logic secondary_selector_in,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// Outputs
	input wire dcc_pkg::dcc_mode_t primary_mode,
	input wire logic hitless_active,
	input wire logic phase_realign,
	input wire logic loop_feedback_copy,
	input wire logic secondary_selected_ref_copy,
	input wire logic diffout_a_oe,
	input wire logic diffout_b_oe
);
	logic [2:0] quiet_q;
	logic [2:0] ctrl_q;
	logic calm;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Settle count and control shadow
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			quiet_q <= 3'h0;
			ctrl_q <= 3'h0;
		end else if (reg_wr && reg_addr == 4'h1) begin
			quiet_q <= 3'h0;
			ctrl_q <= reg_wdata[2:0];
		end else if (quiet_q != 3'h7) begin
			quiet_q <= quiet_q + 3'h1;
		end
	end
	assign calm = quiet_q == 3'h7;
	sequence fb_high_s;
		$rose(primary_feedback_in) ##1 primary_feedback_in [*4];
	endsequence
	sequence sel_high_s;
		$rose(secondary_selector_in) ##1 secondary_selector_in [*4];
	endsequence
	oe_a_a: assert property (calm |-> diffout_a_oe == $past(diffout_a_enable, 3)) else $error("oe a");
	oe_b_a: assert property (calm |-> diffout_b_oe == $past(diffout_b_enable, 3)) else $error("oe b");
	hs_pin_a: assert property (calm && !ctrl_q[1] |-> hitless_active == $past(primary_hitless_enable, 3))
		else $error("hitless pin");
	hs_reg_a: assert property (calm && ctrl_q[1] |-> hitless_active == ctrl_q[0]) else $error("hitless reg");
	mode_pin_a: assert property (calm && !ctrl_q[2]
		|-> primary_mode == $past({primary_mode_pin_hi, primary_mode_pin_lo}, 3)) else $error("mode pins");
	realign_fall_a: assert property ($fell(hitless_active) |-> ##[0:2] phase_realign) else $error("realign");
	realign_one_a: assert property (phase_realign |=> !phase_realign) else $error("realign width");
	fb_copy_a: assert property (fb_high_s |-> loop_feedback_copy) else $error("feedback copy");
	sel_copy_a: assert property (sel_high_s |-> secondary_selected_ref_copy) else $error("sel copy");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0) else $error("rdata idle");
endmodule : dcc_checker
bind dcc_top dcc_checker chk (.*);

/* verification/test_dcc_top.sv */
// Self-checking bench for the loop control block
`timescale 1ns/1ps
module test_dcc_top;
	logic clk_sys, reset, ref_switch_event, reg_wr, reg_rd, fb_w, sel_w;
	logic synth_a, synth_b, fb_copy, sec_copy, hitless_active, phase_realign, a_oe, b_oe;
	logic a_pos, a_neg, b_pos, b_neg;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	dcc_pkg::dcc_mode_t primary_mode;
	dcc_pkg::dcc_ctl_t pins;
	int n_mismatch = 0, tests_run = 0, cycles = 0;
	// Clock and time-zero inputs
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		{reg_wr, reg_rd, ref_switch_event, reg_addr, reg_wdata} = '0;
	end
	dcc_board board (.clk_sys, .reset, .pins, .feedback_wave(fb_w), .selector_wave(sel_w));
	dcc_top DUT (.clk_sys, .reset, .primary_mode_pin_lo(pins.mode_pins[0]), .primary_mode_pin_hi(pins.mode_pins[1]),
		.primary_hitless_enable(pins.hitless), .diffout_a_enable(pins.diff_a_en), .diffout_b_enable(pins.diff_b_en),
		.primary_feedback_in(fb_w), .secondary_selector_in(sel_w), .ref_switch_event, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .primary_mode, .hitless_active, .phase_realign, .synth_b_clock_a(synth_a),
		.synth_b_clock_b(synth_b), .loop_feedback_copy(fb_copy), .secondary_selected_ref_copy(sec_copy),
		.diffout_a_pos(a_pos), .diffout_a_neg(a_neg), .diffout_a_oe(a_oe), .diffout_b_pos(b_pos),
		.diffout_b_neg(b_neg), .diffout_b_oe(b_oe));
	// Verdict and end of run
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	// Hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 check(what, exp, reg_rdata);
	endtask : rd
	task automatic settle();
		repeat (5) @(posedge clk_sys);
		#1;
	endtask : settle
	// Optional reference switch, then count realign pulses
	task automatic pulses(input logic ev, output int c);
		c = 0;
		@(posedge clk_sys);
		ref_switch_event <= ev;
		repeat (8) begin
			@(posedge clk_sys);
			ref_switch_event <= 1'b0;
			#1 c += int'(phase_realign);
		end
	endtask : pulses
	task automatic s_defaults();
		board.power_up(2'h2);
		settle();
		check("mode", 16'h2, 16'(primary_mode));
		rd(4'h0, 16'h0002, "mode reg");
		rd(4'h2, 16'h0608, "synth a rate");
		rd(4'h3, 16'h0002, "synth ratio");
		rd(4'h4, 16'h0004, "diff select");
		rd(4'h5, 16'h001e, "status");
		rd(4'h9, 16'h0000, "unmapped");
	endtask : s_defaults
	task automatic s_enables();
		for (int i = 0; i < 4; i++) begin
			board.drive('{2'h2, 1'b1, i[0], i[1]});
			settle();
			check("oe a", 16'(i[0]), 16'(a_oe));
			check("oe b", 16'(i[1]), 16'(b_oe));
		end
	endtask : s_enables
	task automatic s_hitless();
		int c;
		board.drive('{2'h2, 1'b0, 1'b1, 1'b1});
		pulses(1'b0, c);
		check("realign on disable", 16'h1, 16'(c));
		check("hitless off", 16'h0, 16'(hitless_active));
		pulses(1'b1, c);
		check("realign on switch", 16'h1, 16'(c));
		board.drive('{2'h2, 1'b1, 1'b1, 1'b1});
		settle();
		check("hitless on", 16'h1, 16'(hitless_active));
		pulses(1'b1, c);
		check("no realign", 16'h0, 16'(c));
		wr(4'h1, 16'h0002);
		settle();
		check("sw hitless off", 16'h0, 16'(hitless_active));
		wr(4'h1, 16'h0003);
		settle();
		check("sw hitless on", 16'h1, 16'(hitless_active));
		wr(4'h1, 16'h0000);
	endtask : s_hitless
	task automatic s_modes();
		for (int m = 0; m < 4; m++) begin
			board.drive('{m[1:0], 1'b1, 1'b1, 1'b1});
			settle();
			check("pin mode", 16'(m), 16'(primary_mode));
		end
		wr(4'h1, 16'h0004);
		for (int m = 0; m < 4; m++) begin
			wr(4'h0, 16'(m));
			settle();
			check("reg mode", 16'(m), 16'(primary_mode));
		end
		wr(4'h1, 16'h0000);
	endtask : s_modes
	// Count rising edges over 384 cycles, a whole number of periods for all but the 10-cycle diff clocks
	task automatic count_rises(output int n [6], output int skew);
		logic [5:0] was, now;
		n = '{0, 0, 0, 0, 0, 0};
		skew = 0;
		@(posedge clk_sys);
		#1 was = {b_pos, a_pos, sec_copy, fb_copy, synth_b, synth_a};
		repeat (384) begin
			@(posedge clk_sys);
			#1 now = {b_pos, a_pos, sec_copy, fb_copy, synth_b, synth_a};
			for (int k = 0; k < 6; k++) n[k] += int'(now[k] && !was[k]);
			skew += int'(a_neg !== ~a_pos || b_neg !== ~b_pos);
			was = now;
		end
	endtask : count_rises
	task automatic s_clocks();
		int n [6];
		int skew;
		count_rises(n, skew);
		check("synth a runs", 16'h1, 16'(n[0] > 0));
		check("synth b twice a", 16'(2 * n[0]), 16'(n[1]));
		check("feedback runs", 16'h0018, 16'(n[2]));
		check("selector runs", 16'h000c, 16'(n[3]));
		check("diff a runs", 16'h1, 16'(n[4] > 0));
		check("diff b runs", 16'h1, 16'(n[5] > 0));
		check("diff pairs", 16'h0, 16'(skew));
		wr(4'h1, 16'h0008);
		count_rises(n, skew);
		check("synth b half a", 16'(n[0]), 16'(2 * n[1]));
		wr(4'h1, 16'h0000);
	endtask : s_clocks
	// Main sequence
	initial begin
		s_defaults();
		s_enables();
		s_hitless();
		s_modes();
		s_clocks();
		report_and_stop();
	end
endmodule : test_dcc_top
